// ===== ctl_pkg.sv
// Package with the register layout, timing and carrier types of the control block.
package ctl_pkg;
	localparam int          ADDR_W              = 4;
	localparam logic [3:0]  CTRL_OFFSET         = 4'h0;
	localparam logic [3:0]  DEACT_OFFSET        = 4'h4;
	localparam logic [3:0]  EOI_OFFSET          = 4'h8;
	localparam int          EN_BIT              = 0;
	localparam int          FIQ_BYP_BIT         = 5;
	localparam int          IRQ_BYP_BIT         = 6;
	localparam int          EOI_MODE_BIT        = 9;
	localparam logic [31:0] CTRL_RESET          = 32'h0000_0000;
	localparam logic [31:0] CTRL_WRITE_MASK     = 32'h0000_0261;
	localparam int          ENABLE_DELAY_NS     = 20;
	localparam int          CLK_PERIOD_NS       = 10;
	localparam int          ENABLE_DELAY_CYC    = (ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  ENABLE_DELAY_CNT    = 2'(ENABLE_DELAY_CYC);

	// Decoded control fields of the non-secure control copy.
	typedef struct packed {
		logic eoi_split_mode_nonsecure;
		logic irq_bypass_block_g1;
		logic fiq_bypass_block_g1;
		logic g1_signal_enable;
	} ctrl_fields_t;

	// Completion requests sent toward the active-interrupt tracker.
	typedef struct packed {
		logic        prio_drop;
		logic        deactivate;
		logic [31:0] intid;
	} eoi_req_t;
endpackage

// ===== enable_delay.sv
// Delay line that applies a new signaling enable a fixed count of cycles later.
`timescale 1ns/10ps
`default_nettype none
module enable_delay (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic en_in,
	output logic      en_out
);
	import ctl_pkg::*;

	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic       en_out_q;
	logic       differ;

	// A mismatch starts the countdown; the new value is adopted when it ends.
	assign differ = en_in != en_out_q;
	assign cnt_d  = !differ ? ENABLE_DELAY_CNT : (cnt_q == 2'h1 ? ENABLE_DELAY_CNT : cnt_q - 2'h1);
	assign en_out = en_out_q;

	// Counter and applied enable.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_q    <= ENABLE_DELAY_CNT;
			en_out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			if (differ && cnt_q == 2'h1) begin
				en_out_q <= en_in;
			end
		end
	end

	// A fresh enable value is never applied on the edge right after it changes.
	enable_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$changed(en_in) |=> $stable(en_out))
		else $error("enable applied without delay");
endmodule
`default_nettype wire

// ===== cpu_iface_nonsecure_ctrl.sv
// Non-secure copy of the processor interface control register and its signaling gates.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cpu_iface_nonsecure_ctrl (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic [ctl_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	input  wire logic                 g1_pending,
	input  wire logic                 g1_is_fiq,
	input  wire logic                 g0_irq_in,
	input  wire logic                 g0_fiq_in,
	input  wire logic                 bypass_irq,
	input  wire logic                 bypass_fiq,
	output logic                      irq_out,
	output logic                      fiq_out,
	output logic                      g1_signal_enable,
	output ctl_pkg::ctrl_fields_t     ctrl_fields,
	output ctl_pkg::eoi_req_t         eoi_req,
	output logic                      eoi_valid,
	output logic                      dir_unpredictable
);
	import ctl_pkg::*;

	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        irq_q;
	logic        fiq_q;
	logic        irq_d;
	logic        fiq_d;
	eoi_req_t    eoi_q;
	eoi_req_t    eoi_d;
	logic        eoi_valid_q;
	logic        eoi_valid_d;
	logic        dir_bad_q;
	logic        dir_bad_d;
	logic        en_applied;
	logic        sel_ctrl;
	logic        sel_eoi;
	logic        sel_deact;
	logic        g1_irq_req;
	logic        g1_fiq_req;
	logic        irq_sig_on;
	logic        fiq_sig_on;
	logic        wr_eoi;
	logic        wr_deact;

	// Address decode of the three registers.
	assign sel_ctrl  = reg_addr == CTRL_OFFSET;
	assign sel_eoi   = reg_addr == EOI_OFFSET;
	assign sel_deact = reg_addr == DEACT_OFFSET;

	// Only the defined fields are stored; reserved bits stay zero.
	assign ctrl_d = (reg_wr && sel_ctrl) ? (reg_wdata & CTRL_WRITE_MASK) : ctrl_q;

	// Read data: control register; other addresses read as zero.
	assign rdata_d = (reg_rd && sel_ctrl) ? ctrl_q : 32'h0000_0000;

	// Field view of the stored register, driven as one whole so the struct has a single driver.
	assign ctrl_fields = '{
		eoi_split_mode_nonsecure: ctrl_q[EOI_MODE_BIT],
		irq_bypass_block_g1:      ctrl_q[IRQ_BYP_BIT],
		fiq_bypass_block_g1:      ctrl_q[FIQ_BYP_BIT],
		g1_signal_enable:         ctrl_q[EN_BIT]
	};

	// Group 1 requests pass only with the applied enable set.
	assign g1_irq_req = en_applied && g1_pending && !g1_is_fiq;
	assign g1_fiq_req = en_applied && g1_pending && g1_is_fiq;
	assign irq_sig_on = en_applied;
	assign fiq_sig_on = en_applied;

	// Group 0 lines pass untouched; bypass used only while signaling is off.
	assign irq_d = g0_irq_in || g1_irq_req ||
		(!irq_sig_on && !ctrl_q[IRQ_BYP_BIT] && bypass_irq);
	assign fiq_d = g0_fiq_in || g1_fiq_req ||
		(!fiq_sig_on && !ctrl_q[FIQ_BYP_BIT] && bypass_fiq);

	// End of interrupt drops priority and deactivates unless split mode is on.
	assign wr_eoi             = reg_wr && sel_eoi;
	assign wr_deact           = reg_wr && sel_deact;
	assign eoi_valid_d        = wr_eoi || (wr_deact && ctrl_q[EOI_MODE_BIT]);
	assign eoi_d              = '{
		prio_drop:  wr_eoi,
		deactivate: (wr_eoi && !ctrl_q[EOI_MODE_BIT]) || (wr_deact && ctrl_q[EOI_MODE_BIT]),
		intid:      reg_wdata
	};
	assign dir_bad_d          = wr_deact && !ctrl_q[EOI_MODE_BIT];

	// Enable takes effect after a fixed delay.
	enable_delay u_en_delay (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.en_in   (ctrl_q[EN_BIT]),
		.en_out  (en_applied)
	);

	assign reg_rdata         = rdata_q;
	assign irq_out           = irq_q;
	assign fiq_out           = fiq_q;
	assign g1_signal_enable  = en_applied;
	assign eoi_req           = eoi_q;
	assign eoi_valid         = eoi_valid_q;
	assign dir_unpredictable = dir_bad_q;

	// Register state and output flops.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl_q      <= CTRL_RESET;
			rdata_q     <= 32'h0000_0000;
			irq_q       <= 1'b0;
			fiq_q       <= 1'b0;
			eoi_q       <= '0;
			eoi_valid_q <= 1'b0;
			dir_bad_q   <= 1'b0;
		end else begin
			ctrl_q      <= ctrl_d;
			rdata_q     <= rdata_d;
			irq_q       <= irq_d;
			fiq_q       <= fiq_d;
			eoi_q       <= eoi_d;
			eoi_valid_q <= eoi_valid_d;
			dir_bad_q   <= dir_bad_d;
		end
	end

	// Bypass IRQ is blocked when the block bit is set and signaling is off.
	irq_bypass_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!en_applied && ctrl_q[IRQ_BYP_BIT] && !g0_irq_in) |=> !irq_out)
		else $error("bypass IRQ leaked while blocked");

	// Bypass FIQ passes when the block bit is clear and signaling is off.
	fiq_bypass_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!en_applied && !ctrl_q[FIQ_BYP_BIT] && bypass_fiq) |=> fiq_out)
		else $error("bypass FIQ not passed");

	// A written enable shows on the applied enable after the delay.
	enable_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(reg_wr && sel_ctrl && reg_wdata[EN_BIT] && !ctrl_q[EN_BIT])
		|=> !en_applied ##[1:3] en_applied)
		else $error("enable change not applied in time");

	// With the enable off, group 1 pending alone never raises IRQ.
	g1_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!en_applied && !g0_irq_in && (ctrl_q[IRQ_BYP_BIT] || !bypass_irq)) |=> !irq_out)
		else $error("group 1 IRQ signaled while disabled");

	// With the enable on, a pending group 1 IRQ is signaled.
	g1_process_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(en_applied && g1_pending && !g1_is_fiq) |=> irq_out)
		else $error("group 1 IRQ not signaled");

	// Group 0 FIQ passes whatever this register holds.
	g0_untouched_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		g0_fiq_in |=> fiq_out)
		else $error("group 0 FIQ affected");

	// Reserved bits always read zero.
	reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(reg_rd) |-> reg_rdata[31:10] == 22'h0 && reg_rdata[4:1] == 4'h0 &&
		reg_rdata[8:7] == 2'h0)
		else $error("reserved bits read nonzero");

	// Split mode keeps deactivation off the end of interrupt write.
	eoi_split_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(reg_wr && sel_eoi && ctrl_q[EOI_MODE_BIT]) |=> eoi_valid && !eoi_req.deactivate)
		else $error("split mode end of interrupt deactivated");

	// Enable bit reads back as written.
	enable_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(reg_wr && sel_ctrl) |=> ctrl_fields.g1_signal_enable == $past(reg_wdata[EN_BIT]))
		else $error("enable bit not stored");

	// Bypass IRQ passes when the block bit is clear and signaling is off.
	irq_bypass_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!en_applied && !ctrl_q[IRQ_BYP_BIT] && bypass_irq) |=> irq_out)
		else $error("bypass IRQ not passed");

	// Bypass FIQ is blocked when the block bit is set and signaling is off.
	fiq_bypass_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!en_applied && ctrl_q[FIQ_BYP_BIT] && !g0_fiq_in) |=> !fiq_out)
		else $error("bypass FIQ leaked while blocked");

	// With signaling on, the bypass IRQ line is never passed through.
	bypass_ignored_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(en_applied && !g0_irq_in && !(g1_pending && !g1_is_fiq)) |=> !irq_out)
		else $error("bypass IRQ passed while signaling is on");

	// With the enable on, a pending group 1 FIQ is signaled.
	g1_fiq_process_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(en_applied && g1_pending && g1_is_fiq) |=> fiq_out)
		else $error("group 1 FIQ not signaled");

	// Group 0 IRQ passes whatever this register holds.
	g0_irq_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		g0_irq_in |=> irq_out)
		else $error("group 0 IRQ affected");

	// Without split mode the end of interrupt write both drops priority and deactivates.
	eoi_joint_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_eoi && !ctrl_q[EOI_MODE_BIT])
		|=> eoi_valid && eoi_req.prio_drop && eoi_req.deactivate)
		else $error("joint end of interrupt incomplete");

	// Without split mode a deactivate write raises no request, only the warning pulse.
	dir_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wr_deact && !ctrl_q[EOI_MODE_BIT]) |=> dir_unpredictable && !eoi_valid)
		else $error("deactivate write without split mode not flagged");

	// Bits outside the defined fields are never stored.
	reserved_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ctrl_q & ~CTRL_WRITE_MASK) == 32'h0000_0000)
		else $error("reserved control bits stored");
endmodule
`default_nettype wire

// ===== proc_model.sv
// Processor-side model that takes each new IRQ assertion as one interrupt entry.
`timescale 1ns/10ps
`default_nettype none
module proc_model (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       irq,
	output logic      [7:0] n_irq
);
	logic irq_q;

	// A rising edge of the line counts as one entry, so a held level is taken once.
	always_ff @(posedge sys_clk) begin
		irq_q <= rst_n & irq;
		if (!rst_n) begin
			n_irq <= 8'h00;
		end else if (irq && !irq_q) begin
			n_irq <= n_irq + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the non-secure processor interface control block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ctl_pkg::*;
	logic         sys_clk, rst_n, reg_wr, reg_rd, g1_pending, g1_is_fiq;
	logic         g0_irq_in, g0_fiq_in, bypass_irq, bypass_fiq;
	logic         irq_out, fiq_out, g1_signal_enable, eoi_valid, dir_unpredictable;
	logic [3:0]   reg_addr;
	logic [31:0]  reg_wdata, reg_rdata;
	ctrl_fields_t ctrl_fields;
	eoi_req_t     eoi_req;
	logic [7:0]   n_irq;
	logic [10:0]  rows [8];
	int           errors, n_compared, cyc;

	cpu_iface_nonsecure_ctrl cpu_iface_nonsecure_ctrl_inst (.sys_clk, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .g1_pending, .g1_is_fiq, .g0_irq_in,
		.g0_fiq_in, .bypass_irq, .bypass_fiq, .irq_out, .fiq_out, .g1_signal_enable,
		.ctrl_fields, .eoi_req, .eoi_valid, .dir_unpredictable);
	proc_model proc_model_inst (.sys_clk, .rst_n, .irq(irq_out), .n_irq);

	// Free-running 100 MHz clock.
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic report_and_stop();
		$display("errors=%0d n_compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One write cycle; returns in the time step of the edge that took the strobe.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask

	// One read cycle; the data are looked at in the single cycle they stand.
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 chk("reg_rdata", 34'(e), 34'(reg_rdata));
	endtask

	// Hang guard: the whole sequence needs well under this many cycles.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			report_and_stop();
		end
	end

	// Rows: {enable, irq block, fiq block, pend, is_fiq, g0 irq, g0 fiq, byp irq, byp fiq, irq, fiq}.
	initial begin
		rows = '{11'h00F, 11'h20D, 11'h10E, 11'h38C, 11'h333, 11'h782, 11'h4C1, 11'h40C};
		{rst_n, reg_wr, reg_rd, g1_pending, g1_is_fiq, g0_irq_in, g0_fiq_in} = '0;
		{bypass_irq, bypass_fiq, reg_addr, reg_wdata} = '0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'h1;
		rd(CTRL_OFFSET, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			wr(CTRL_OFFSET, {25'h0, rows[i][9:8], 4'h0, rows[i][10]});
			{g1_pending, g1_is_fiq, g0_irq_in, g0_fiq_in, bypass_irq, bypass_fiq} <= rows[i][7:2];
			repeat (5) @(posedge sys_clk);
			#1 chk("irq_fiq", 34'(rows[i][1:0]), 34'({irq_out, fiq_out}));
		end
		chk("n_irq", 34'h4, 34'(n_irq));
		wr(CTRL_OFFSET, 32'hFFFF_FFFF);
		#1 chk("ctrl_fields_all", 34'hF, 34'(ctrl_fields));
		rd(CTRL_OFFSET, 32'h0000_0261);
		rd(4'hC, 32'h0000_0000);
		wr(CTRL_OFFSET, 32'h0000_0000);
		repeat (4) @(posedge sys_clk);
		wr(CTRL_OFFSET, 32'h0000_0001);
		@(posedge sys_clk);
		#1 chk("ctrl_enable", 34'h1, 34'(ctrl_fields.g1_signal_enable));
		chk("applied_enable_early", 34'h0, 34'(g1_signal_enable));
		repeat (2) @(posedge sys_clk);
		#1 chk("applied_enable", 34'h1, 34'(g1_signal_enable));
		wr(EOI_OFFSET, 32'h0000_0025);
		#1 chk("eoi_joint", {2'h3, 32'h0000_0025}, eoi_req);
		chk("eoi_joint_flags", 34'h2, 34'({eoi_valid, dir_unpredictable}));
		wr(DEACT_OFFSET, 32'h0000_0025);
		#1 chk("dir_bad", 34'h1, 34'({eoi_valid, dir_unpredictable}));
		wr(CTRL_OFFSET, 32'h0000_0201);
		#1 chk("ctrl_fields_split", 34'h9, 34'(ctrl_fields));
		wr(EOI_OFFSET, 32'h0000_0025);
		#1 chk("eoi_split", {2'h2, 32'h0000_0025}, eoi_req);
		chk("eoi_split_flags", 34'h2, 34'({eoi_valid, dir_unpredictable}));
		wr(DEACT_OFFSET, 32'h0000_0025);
		#1 chk("dir_split", {2'h1, 32'h0000_0025}, eoi_req);
		chk("dir_split_flags", 34'h2, 34'({eoi_valid, dir_unpredictable}));
		// Second reset in mid-run must clear the register and the applied enable.
		@(posedge sys_clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'h1;
		#1 chk("reset_applied_enable", 34'h0, 34'(g1_signal_enable));
		rd(CTRL_OFFSET, 32'h0000_0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
